// File: mioad_params.svh
`ifndef MIOAD_PARAMS_SVH
`define MIOAD_PARAMS_SVH

// Memory space byte addresses
`define MIOAD_MMR_HI      24'h0000BF
`define MIOAD_DAR_HI      24'h00FFFF
`define MIOAD_SAR_HI      24'h04FFFF
`define MIOAD_EXT_LO      24'h050000
`define MIOAD_EXT_HI      24'hFFFFFF
`define MIOAD_CS2_LO      24'h400000
`define MIOAD_CS3_LO      24'h800000
`define MIOAD_CS4_LO      24'hC00000
`define MIOAD_CS5_LO      24'hE00000
`define MIOAD_BLK_LSB     13
`define MIOAD_SAR_BLK0    6'h08
`define MIOAD_EXT_AW      21

// Chip select pin numbers
`define MIOAD_PIN_CS0     0
`define MIOAD_PIN_CS1     1
`define MIOAD_PIN_CS2     2
`define MIOAD_PIN_CS3     3
`define MIOAD_PIN_CS4     4
`define MIOAD_PIN_CS5     5
`define MIOAD_NPIN        6

// Masters
`define MIOAD_M_CORE      0
`define MIOAD_M_DMA0      1
`define MIOAD_M_DMA3      4
`define MIOAD_M_LCD       5
`define MIOAD_M_USB       6
`define MIOAD_NMST        7

// Arbitrated targets
`define MIOAD_NDAR        8
`define MIOAD_NSAR        32
`define MIOAD_T_SAR0      8
`define MIOAD_T_MMR       40
`define MIOAD_T_EXT       41
`define MIOAD_T_IO        42
`define MIOAD_NTGT        43
`define MIOAD_DAR_PORTS   2

// I/O space word address windows
`define MIOAD_IDLE_LO     16'h0000
`define MIOAD_IDLE_HI     16'h0004
`define MIOAD_DMA_LO      16'h0C00
`define MIOAD_DMA_STEP    16'h0100
`define MIOAD_DMA_SIZE    16'h0080
`define MIOAD_EXTERNAL_MEMORY_INTERFACE_LO     16'h1000
`define MIOAD_EXTERNAL_MEMORY_INTERFACE_HI     16'h10DD
`define MIOAD_TMR_LO      16'h1800
`define MIOAD_TMR_STEP    16'h0040
`define MIOAD_TMR_SIZE    16'h0020
`define MIOAD_RTC_LO      16'h1900
`define MIOAD_RTC_HI      16'h197F
`define MIOAD_I2C_LO      16'h1A00
`define MIOAD_I2C_HI      16'h1A6C
`define MIOAD_UART_LO     16'h1B00
`define MIOAD_UART_HI     16'h1B1F
`define MIOAD_SYSC_LO     16'h1C00
`define MIOAD_SYSC_HI     16'h1CFF
`define MIOAD_AUD_LO      16'h2800
`define MIOAD_AUD_STEP    16'h0100
`define MIOAD_AUD_SPAN    16'h0040
`define MIOAD_LCD_LO      16'h2E00
`define MIOAD_LCD_HI      16'h2E40
`define MIOAD_SPI_LO      16'h3000
`define MIOAD_SPI_HI      16'h300F
`define MIOAD_MMC0_LO     16'h3A00
`define MIOAD_MMC0_HI     16'h3A7F
`define MIOAD_MMC1_LO     16'h3B00
`define MIOAD_MMC1_HI     16'h3B1F
`define MIOAD_ADC_LO      16'h7000
`define MIOAD_ADC_HI      16'h70FF
`define MIOAD_USB_LO      16'h8000
`define MIOAD_USB_HI      16'hFFFF

`endif

// File: mioad_pkg.sv
`default_nettype none
package mioad_pkg;
	typedef enum logic [2:0] {
		TC_NONE,
		TC_MMR,
		TC_DAR,
		TC_SAR,
		TC_EXT,
		TC_IO
	} mioad_tclass_t;

	typedef enum logic [4:0] {
		PH_NONE,
		PH_IDLE,
		PH_DMA0,
		PH_DMA1,
		PH_DMA2,
		PH_DMA3,
		PH_EXTERNAL_MEMORY_INTERFACE,
		PH_TMR0,
		PH_TMR1,
		PH_TMR2,
		PH_RTC,
		PH_I2C,
		PH_UART,
		PH_SYSC,
		PH_AUD0,
		PH_AUD1,
		PH_AUD2,
		PH_AUD3,
		PH_LCD,
		PH_SPI,
		PH_MMC0,
		PH_MMC1,
		PH_ADC,
		PH_USB
	} mioad_periph_t;
endpackage
`default_nettype wire

// File: mioad_arbiter.sv
`default_nettype none
// Fixed priority: lowest master index first, up to PORTS grants per cycle
module mioad_arbiter #(
	parameter int N     = 7,
	parameter int PORTS = 1
) (
	input  wire logic [N-1:0] req,
	output logic      [N-1:0] gnt
);
	always_comb begin
		int cnt;
		cnt = 0;
		gnt = '0;
		for (int i = 0; i < N; i++) begin
			if (req[i] && (cnt < PORTS)) begin
				gnt[i] = 1'b1;
				cnt = cnt + 1;
			end
		end
	end
endmodule
`default_nettype wire

// File: mioad_decoder.sv
// Behaviour
// - Bytes 050000h through FFFFFFh go to the external memory interface.
// - External space has five regions; first is SDRAM, others async memories.
// - Each region asserts its own active-low chip select during access.
// - External bus is 16 or 8 bits wide with up to 21 address bits.
// - Separate 64K I/O space, reached only by core I/O access or DMA.
// - DMA engines reach serial, audio, card, memory, USB and converter registers.
// - Decode idle, DMA, external interface and timer I/O windows.
// - Decode clock, serial, system, audio, display, card, converter, USB windows.
// - Dual-access RAM: eight 8K blocks, two accesses per block per cycle.
// - Single-access RAM: 32 8K blocks, one access per block per cycle.
// - Accept requests from core, four DMA, display and USB masters.
// - Unmapped reads return zero; unmapped writes do nothing and complete.
// - Display and USB masters have no path to dual-access RAM.
// - First region selects by chip select 0 alone or 0 and 1 together.
// - Lowest 192 bytes decode to core mapped registers.
// - Unified memory space spans 16M bytes.
// - Dual-access RAM at 000000h-00FFFFh; single-access at 010000h-04FFFFh.
`default_nettype none
`include "mioad_params.svh"
module mioad_decoder #(
	parameter int NM = `MIOAD_NMST,
	parameter int DW = 16
) (
	input  wire logic                               clk_sys,
	input  wire logic                               rst_b,
	input  wire logic                               ext_cs_pair,
	input  wire logic                               ext_bus_8bit,
	input  wire logic [NM-1:0]                      mst_req,
	input  wire logic [NM-1:0]                      mst_io,
	input  wire logic [NM-1:0]                      mst_we,
	input  wire logic [NM-1:0][23:0]                mst_addr,
	input  wire logic [NM-1:0][DW-1:0]              tgt_rdata,
	output logic      [NM-1:0]                      mst_ack_r,
	output mioad_pkg::mioad_tclass_t [NM-1:0]       mst_class_r,
	output logic      [NM-1:0][4:0]                 mst_block_r,
	output logic      [NM-1:0][DW-1:0]              mst_rdata_r,
	output logic      [`MIOAD_NPIN-1:0]             ext_region_select_b_r,
	output logic      [`MIOAD_EXT_AW-1:0]           ext_addr_r,
	output logic                                    ext_we_r,
	output logic                                    ext_active_r,
	output logic                                    io_sel_r,
	output mioad_pkg::mioad_periph_t                io_periph_r,
	output logic      [15:0]                        io_addr_r,
	output logic                                    io_we_r
);
	import mioad_pkg::*;

	function automatic logic in_rng(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		in_rng = (a >= lo) && (a <= hi);
	endfunction

	function automatic mioad_periph_t io_decode(input logic [15:0] a);
		logic [15:0] lo;
		io_decode = PH_NONE;
		lo = 16'h0000;
		if (in_rng(a, `MIOAD_IDLE_LO, `MIOAD_IDLE_HI)) io_decode = PH_IDLE;
		for (int i = 0; i < 4; i++) begin
			lo = 16'(`MIOAD_DMA_LO + i * `MIOAD_DMA_STEP);
			if (in_rng(a, lo, 16'(lo + `MIOAD_DMA_SIZE - 16'h0001))) begin
				io_decode = mioad_periph_t'(5'(PH_DMA0) + 5'(i));
			end
		end
		if (in_rng(a, `MIOAD_EXTERNAL_MEMORY_INTERFACE_LO, `MIOAD_EXTERNAL_MEMORY_INTERFACE_HI)) io_decode = PH_EXTERNAL_MEMORY_INTERFACE;
		for (int i = 0; i < 3; i++) begin
			lo = 16'(`MIOAD_TMR_LO + i * `MIOAD_TMR_STEP);
			if (in_rng(a, lo, 16'(lo + `MIOAD_TMR_SIZE - 16'h0001))) begin
				io_decode = mioad_periph_t'(5'(PH_TMR0) + 5'(i));
			end
		end
		if (in_rng(a, `MIOAD_RTC_LO, `MIOAD_RTC_HI)) io_decode = PH_RTC;
		if (in_rng(a, `MIOAD_I2C_LO, `MIOAD_I2C_HI)) io_decode = PH_I2C;
		if (in_rng(a, `MIOAD_UART_LO, `MIOAD_UART_HI)) io_decode = PH_UART;
		if (in_rng(a, `MIOAD_SYSC_LO, `MIOAD_SYSC_HI)) io_decode = PH_SYSC;
		for (int i = 0; i < 4; i++) begin
			lo = 16'(`MIOAD_AUD_LO + i * `MIOAD_AUD_STEP);
			if (in_rng(a, lo, 16'(lo + `MIOAD_AUD_SPAN))) begin
				io_decode = mioad_periph_t'(5'(PH_AUD0) + 5'(i));
			end
		end
		if (in_rng(a, `MIOAD_LCD_LO, `MIOAD_LCD_HI)) io_decode = PH_LCD;
		if (in_rng(a, `MIOAD_SPI_LO, `MIOAD_SPI_HI)) io_decode = PH_SPI;
		if (in_rng(a, `MIOAD_MMC0_LO, `MIOAD_MMC0_HI)) io_decode = PH_MMC0;
		if (in_rng(a, `MIOAD_MMC1_LO, `MIOAD_MMC1_HI)) io_decode = PH_MMC1;
		if (in_rng(a, `MIOAD_ADC_LO, `MIOAD_ADC_HI)) io_decode = PH_ADC;
		if (in_rng(a, `MIOAD_USB_LO, `MIOAD_USB_HI)) io_decode = PH_USB;
	endfunction

	// Whole 24-bit byte space is covered by exactly one class
	function automatic mioad_tclass_t mem_decode(input logic [23:0] a);
		if (a <= `MIOAD_MMR_HI) begin
			mem_decode = TC_MMR;
		end else if (a <= `MIOAD_DAR_HI) begin
			mem_decode = TC_DAR;
		end else if (a <= `MIOAD_SAR_HI) begin
			mem_decode = TC_SAR;
		end else begin
			mem_decode = TC_EXT;
		end
	endfunction

	// Region as chip select pin number, first region reported as pin 0
	function automatic logic [2:0] ext_region(input logic [23:0] a);
		if (a >= `MIOAD_CS5_LO) begin
			ext_region = 3'(`MIOAD_PIN_CS5);
		end else if (a >= `MIOAD_CS4_LO) begin
			ext_region = 3'(`MIOAD_PIN_CS4);
		end else if (a >= `MIOAD_CS3_LO) begin
			ext_region = 3'(`MIOAD_PIN_CS3);
		end else if (a >= `MIOAD_CS2_LO) begin
			ext_region = 3'(`MIOAD_PIN_CS2);
		end else begin
			ext_region = 3'(`MIOAD_PIN_CS0);
		end
	endfunction

	function automatic logic [23:0] ext_base(input logic [2:0] r);
		case (r)
			3'(`MIOAD_PIN_CS2): ext_base = `MIOAD_CS2_LO;
			3'(`MIOAD_PIN_CS3): ext_base = `MIOAD_CS3_LO;
			3'(`MIOAD_PIN_CS4): ext_base = `MIOAD_CS4_LO;
			3'(`MIOAD_PIN_CS5): ext_base = `MIOAD_CS5_LO;
			default: ext_base = `MIOAD_EXT_LO;
		endcase
	endfunction

	mioad_tclass_t [NM-1:0]         cls_nxt;
	logic          [NM-1:0][4:0]    blk_nxt;
	logic          [NM-1:0][5:0]    tgt_nxt;
	mioad_periph_t [NM-1:0]         per_nxt;
	logic          [NM-1:0]         live;
	logic          [NM-1:0]         win;
	logic          [NM-1:0]         taken;
	logic [`MIOAD_NTGT-1:0][NM-1:0] tgt_req;
	logic [`MIOAD_NTGT-1:0][NM-1:0] tgt_gnt;

	// Per-master decode to one class and one arbitrated target
	always_comb begin
		for (int m = 0; m < NM; m++) begin
			per_nxt[m] = io_decode(mst_addr[m][15:0]);
			blk_nxt[m] = 5'h00;
			tgt_nxt[m] = 6'h00;
			if (mst_io[m]) begin
				// I/O only for core and DMA, reserved holes are unmapped
				if ((m <= `MIOAD_M_DMA3) && (per_nxt[m] != PH_NONE)) begin
					cls_nxt[m] = TC_IO;
				end else begin
					cls_nxt[m] = TC_NONE;
				end
			end else begin
				cls_nxt[m] = mem_decode(mst_addr[m]);
			end
			// Display and USB masters fall through to the unmapped answer on dual RAM and mapped registers
			if (((m == `MIOAD_M_LCD) || (m == `MIOAD_M_USB)) &&
				((cls_nxt[m] == TC_DAR) || (cls_nxt[m] == TC_MMR))) begin
				cls_nxt[m] = TC_NONE;
			end
			case (cls_nxt[m])
				TC_MMR: begin
					tgt_nxt[m] = 6'(`MIOAD_T_MMR);
				end
				TC_DAR: begin
					blk_nxt[m] = {2'b00, mst_addr[m][`MIOAD_BLK_LSB+2:`MIOAD_BLK_LSB]};
					tgt_nxt[m] = {1'b0, blk_nxt[m]};
				end
				TC_SAR: begin
					blk_nxt[m] = 5'(mst_addr[m][`MIOAD_BLK_LSB+5:`MIOAD_BLK_LSB] -
						`MIOAD_SAR_BLK0);
					tgt_nxt[m] = 6'(`MIOAD_T_SAR0) + {1'b0, blk_nxt[m]};
				end
				TC_EXT: begin
					blk_nxt[m] = {2'b00, ext_region(mst_addr[m])};
					tgt_nxt[m] = 6'(`MIOAD_T_EXT);
				end
				TC_IO: begin
					blk_nxt[m] = 5'(per_nxt[m]);
					tgt_nxt[m] = 6'(`MIOAD_T_IO);
				end
				default: begin
					tgt_nxt[m] = 6'h00;
				end
			endcase
			// A master waits one cycle after its acknowledge before the next take
			live[m] = mst_req[m] && !mst_ack_r[m];
		end
	end

	always_comb begin
		for (int t = 0; t < `MIOAD_NTGT; t++) begin
			for (int m = 0; m < NM; m++) begin
				tgt_req[t][m] = live[m] && (cls_nxt[m] != TC_NONE) &&
					(tgt_nxt[m] == 6'(t));
			end
		end
	end

	genvar gt;
	generate
		for (gt = 0; gt < `MIOAD_NTGT; gt++) begin : g_arb
			localparam int PORTS = ((gt < `MIOAD_NDAR) || (gt == `MIOAD_T_MMR)) ?
				`MIOAD_DAR_PORTS : 1;
			mioad_arbiter #(
				.N     (NM),
				.PORTS (PORTS)
			) u_arb (
				.req (tgt_req[gt]),
				.gnt (tgt_gnt[gt])
			);
		end
	endgenerate

	always_comb begin
		for (int m = 0; m < NM; m++) begin
			win[m] = 1'b0;
			for (int t = 0; t < `MIOAD_NTGT; t++) begin
				win[m] = win[m] | tgt_gnt[t][m];
			end
			// Unmapped accesses never stall
			taken[m] = live[m] && (win[m] || (cls_nxt[m] == TC_NONE));
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			mst_ack_r   <= '0;
			for (int m = 0; m < NM; m++) begin
				mst_class_r[m] <= TC_NONE;
			end
			mst_block_r <= '0;
			mst_rdata_r <= '0;
		end else begin
			for (int m = 0; m < NM; m++) begin
				mst_ack_r[m] <= taken[m];
				if (taken[m]) begin
					mst_class_r[m] <= cls_nxt[m];
					mst_block_r[m] <= blk_nxt[m];
					if (cls_nxt[m] == TC_NONE) begin
						mst_rdata_r[m] <= '0;
					end else begin
						mst_rdata_r[m] <= tgt_rdata[m];
					end
				end
			end
		end
	end

	// External bus: one access per cycle, owner is the lone granted master
	logic [NM-1:0]            ext_win;
	logic [23:0]              ext_off;
	logic [2:0]               ext_reg;
	logic [`MIOAD_NPIN-1:0]   cs_nxt;
	logic                     ext_hit;
	logic                     ext_wr;
	logic [`MIOAD_EXT_AW-1:0] ext_a_nxt;

	always_comb begin
		ext_win = tgt_gnt[`MIOAD_T_EXT] & taken;
		ext_hit = |ext_win;
		ext_reg = 3'h0;
		ext_off = 24'h000000;
		ext_wr = 1'b0;
		for (int m = 0; m < NM; m++) begin
			if (ext_win[m]) begin
				ext_reg = blk_nxt[m][2:0];
				ext_off = mst_addr[m] - ext_base(blk_nxt[m][2:0]);
				ext_wr = mst_we[m];
			end
		end
		if (ext_bus_8bit) begin
			ext_a_nxt = ext_off[`MIOAD_EXT_AW-1:0];
		end else begin
			ext_a_nxt = ext_off[`MIOAD_EXT_AW:1];
		end
		cs_nxt = {`MIOAD_NPIN{1'b1}};
		if (ext_hit) begin
			cs_nxt[ext_reg] = 1'b0;
			if ((ext_reg == 3'(`MIOAD_PIN_CS0)) && ext_cs_pair) begin
				cs_nxt[`MIOAD_PIN_CS1] = 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			ext_region_select_b_r <= {`MIOAD_NPIN{1'b1}};
			ext_addr_r            <= '0;
			ext_we_r              <= 1'b0;
			ext_active_r          <= 1'b0;
		end else begin
			ext_region_select_b_r <= cs_nxt;
			ext_active_r          <= ext_hit;
			ext_we_r              <= ext_hit && ext_wr;
			if (ext_hit) begin
				ext_addr_r <= ext_a_nxt;
			end
		end
	end

	// I/O window select, one access per cycle
	logic [NM-1:0]  io_win;
	logic           io_hit;
	mioad_periph_t  io_per;
	logic [15:0]    io_a;
	logic           io_wr;

	always_comb begin
		io_win = tgt_gnt[`MIOAD_T_IO] & taken;
		io_hit = |io_win;
		io_per = PH_NONE;
		io_a = 16'h0000;
		io_wr = 1'b0;
		for (int m = 0; m < NM; m++) begin
			if (io_win[m]) begin
				io_per = per_nxt[m];
				io_a = mst_addr[m][15:0];
				io_wr = mst_we[m];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			io_sel_r    <= 1'b0;
			io_periph_r <= PH_NONE;
			io_addr_r   <= 16'h0000;
			io_we_r     <= 1'b0;
		end else begin
			io_sel_r    <= io_hit;
			io_periph_r <= io_hit ? io_per : PH_NONE;
			io_we_r     <= io_hit && io_wr;
			if (io_hit) begin
				io_addr_r <= io_a;
			end
		end
	end
endmodule
`default_nettype wire

// File: mioad_decoder_sva.sv
`default_nettype none
module mioad_decoder_sva
	import mioad_pkg::*;
#(
	parameter int NM = 7,
	parameter int DW = 16
) (
	input wire logic                             clk_sys,
	input wire logic                             rst_b,
	input wire logic                             ext_cs_pair,
	input wire logic [NM-1:0]                    mst_ack_r,
	input wire mioad_pkg::mioad_tclass_t [NM-1:0] mst_class_r,
	input wire logic [NM-1:0][4:0]               mst_block_r,
	input wire logic [NM-1:0][DW-1:0]            mst_rdata_r,
	input wire logic [5:0]                       ext_region_select_b_r,
	input wire logic                             ext_we_r,
	input wire logic                             ext_active_r,
	input wire logic                             io_sel_r,
	input wire mioad_pkg::mioad_periph_t         io_periph_r,
	input wire logic                             io_we_r
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	int n_ext;
	// Number of masters answered from external space this cycle
	always_comb begin
		n_ext = 0;
		for (int m = 0; m < NM; m++) begin
			n_ext += int'(mst_ack_r[m] && mst_class_r[m] == TC_EXT);
		end
	end
	property p_ack_pulse; mst_ack_r[0] |=> !mst_ack_r[0]; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_cs_act; ext_active_r == (ext_region_select_b_r != 6'h3F); endproperty
	a_cs_act: assert property (p_cs_act) else $error("chip select without access");
	property p_cs_one;
		$countones(~ext_region_select_b_r) <= 2 && (ext_region_select_b_r[1] || !ext_region_select_b_r[0]);
	endproperty
	a_cs_one: assert property (p_cs_one) else $error("overlapping chip selects");
	property p_cs_pair; !ext_region_select_b_r[0] |-> ext_region_select_b_r[1] != $past(ext_cs_pair); endproperty
	a_cs_pair: assert property (p_cs_pair) else $error("first region select form wrong");
	property p_ext_one; n_ext <= 1 && ext_active_r == (n_ext == 1); endproperty
	a_ext_one: assert property (p_ext_one) else $error("external strobe mismatch");
	property p_ext_we; ext_we_r |-> ext_active_r; endproperty
	a_ext_we: assert property (p_ext_we) else $error("external write without access");
	property p_io_sel; io_sel_r == (io_periph_r != PH_NONE); endproperty
	a_io_sel: assert property (p_io_sel) else $error("io select and peripheral disagree");
	property p_io_we; io_we_r |-> io_sel_r; endproperty
	a_io_we: assert property (p_io_we) else $error("io write without select");
	property p_unmap; mst_ack_r[6] && mst_class_r[6] == TC_NONE |-> mst_rdata_r[6] == 16'h0000; endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_no_dar; !(mst_class_r[5] inside {TC_DAR, TC_MMR} || mst_class_r[6] inside {TC_DAR, TC_MMR}); endproperty
	a_no_dar: assert property (p_no_dar) else $error("display or usb reached dual ram");
	property p_dar_blk; mst_class_r[0] == TC_DAR |-> mst_block_r[0] < 5'h08; endproperty
	a_dar_blk: assert property (p_dar_blk) else $error("dual ram block out of range");
	property p_sar_one;
		!(mst_ack_r[0] && mst_ack_r[1] && mst_class_r[0] == TC_SAR && mst_class_r[1] == TC_SAR
			&& mst_block_r[0] == mst_block_r[1]);
	endproperty
	a_sar_one: assert property (p_sar_one) else $error("two grants on one single ram block");
endmodule
bind mioad_decoder mioad_decoder_sva #(.NM(NM), .DW(DW)) i_mioad_decoder_sva (.clk_sys(clk_sys),
	.rst_b(rst_b), .ext_cs_pair(ext_cs_pair), .mst_ack_r(mst_ack_r), .mst_class_r(mst_class_r),
	.mst_block_r(mst_block_r), .mst_rdata_r(mst_rdata_r),
	.ext_region_select_b_r(ext_region_select_b_r), .ext_we_r(ext_we_r),
	.ext_active_r(ext_active_r), .io_sel_r(io_sel_r), .io_periph_r(io_periph_r), .io_we_r(io_we_r));
`default_nettype wire

// File: mioad_target_model.sv
`default_nettype none
module mioad_target_model #(
	parameter int NM = 7,
	parameter int DW = 16
) (
	input  wire logic [NM-1:0][23:0]   mst_addr,
	output logic      [NM-1:0][DW-1:0] tgt_rdata
);
	timeunit 1ns;
	timeprecision 1ns;
	// Word depends on address and master so a wrong steer shows in the data
	always_comb begin
		for (int m = 0; m < NM; m++) begin
			tgt_rdata[m] = DW'(mst_addr[m][15:0] ^ (16'hA5C3 + m));
		end
	end
endmodule
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import mioad_pkg::*;
	logic                 clk_sys = 0, rst_b = 0, ext_cs_pair = 0, ext_bus_8bit = 0;
	logic [6:0]           mst_req = '0, mst_io = '0, mst_we = '0, mst_ack_r;
	logic [6:0][23:0]     mst_addr = '0;
	logic [6:0][15:0]     tgt_rdata, mst_rdata_r;
	mioad_tclass_t [6:0]  mst_class_r;
	logic [6:0][4:0]      mst_block_r;
	logic [5:0]           ext_region_select_b_r;
	logic [20:0]          ext_addr_r;
	logic                 ext_we_r, ext_active_r, io_sel_r, io_we_r;
	mioad_periph_t        io_periph_r;
	logic [15:0]          io_addr_r;
	int                   failures = 0, checks_done = 0, cyc = 0, seed = 32'hF39D, t_ack[7];
	int lo[24] = '{16'h0, 16'h0, 16'h0C00, 16'h0D00, 16'h0E00, 16'h0F00, 16'h1000, 16'h1800,
		16'h1840, 16'h1880, 16'h1900, 16'h1A00, 16'h1B00, 16'h1C00, 16'h2800, 16'h2900,
		16'h2A00, 16'h2B00, 16'h2E00, 16'h3000, 16'h3A00, 16'h3B00, 16'h7000, 16'h8000};
	int sz[24] = '{16'h0, 16'h5, 16'h80, 16'h80, 16'h80, 16'h80, 16'hDE, 16'h20, 16'h20,
		16'h20, 16'h80, 16'h6D, 16'h20, 16'h100, 16'h41, 16'h41, 16'h41, 16'h41, 16'h41,
		16'h10, 16'h80, 16'h20, 16'h100, 16'h8000};
	int mb[8] = '{24'h0, 24'hC0, 24'h10000, 24'h50000, 24'h400000, 24'h800000, 24'hC00000,
		24'hE00000};
	int ms[8] = '{24'hC0, 24'hFF40, 24'h40000, 24'h3B0000, 24'h100000, 24'h100000,
		24'h100000, 24'h100000};
	int edges[11] = '{24'hBF, 24'hC0, 24'hFFFF, 24'h10000, 24'h4FFFF, 24'h50000, 24'h3FFFFF,
		24'h400000, 24'hDFFFFF, 24'hE00000, 24'hFFFFFF};

	mioad_decoder #(.NM(7), .DW(16)) i_mioad_decoder (.clk_sys(clk_sys), .rst_b(rst_b),
		.ext_cs_pair(ext_cs_pair), .ext_bus_8bit(ext_bus_8bit), .mst_req(mst_req),
		.mst_io(mst_io), .mst_we(mst_we), .mst_addr(mst_addr), .tgt_rdata(tgt_rdata),
		.mst_ack_r(mst_ack_r), .mst_class_r(mst_class_r), .mst_block_r(mst_block_r),
		.mst_rdata_r(mst_rdata_r), .ext_region_select_b_r(ext_region_select_b_r),
		.ext_addr_r(ext_addr_r), .ext_we_r(ext_we_r), .ext_active_r(ext_active_r),
		.io_sel_r(io_sel_r), .io_periph_r(io_periph_r), .io_addr_r(io_addr_r), .io_we_r(io_we_r));
	mioad_target_model i_mioad_target_model (.mst_addr(mst_addr), .tgt_rdata(tgt_rdata));

	initial forever #50 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			results();
		end
	end

	task automatic results();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
		end
	endtask

	task automatic do_reset();
		@(negedge clk_sys);
		rst_b = 0;
		repeat (8) @(negedge clk_sys);
		check(mst_ack_r, 0);
		check(ext_region_select_b_r, 6'h3F);
		check(io_periph_r, PH_NONE);
		rst_b = 1;
	endtask

	// Reference decode: class, block or peripheral (-1 when not checked), chip select pin
	task automatic model(input int m, input bit io, input int a, output int c, output int b,
		output int pin);
		pin = -1;
		b = -1;
		if (io) begin
			c = (m >= 5) ? TC_NONE : TC_IO;
			for (int k = 1; k < 24; k++)
				if (a >= lo[k] && a < lo[k] + sz[k])
					b = k;
		end else if (a < 24'hC0)
			c = TC_MMR;
		else if (a < 24'h10000) begin
			c = TC_DAR;
			b = a >> 13;
		end else if (a < 24'h50000) begin
			c = TC_SAR;
			b = (a >> 13) - 8;
		end else begin
			c = TC_EXT;
			pin = a < 24'h400000 ? 0 : a < 24'h800000 ? 2 : a < 24'hC00000 ? 3 : a < 24'hE00000 ? 4 : 5;
			b = pin;
		end
		if (m >= 5 && (c == TC_DAR || c == TC_MMR))
			c = TC_NONE;
		if (c == TC_NONE)
			b = -1;
	endtask

	task automatic access(input int m, input bit io, input bit we, input int a);
		int c, b, pin, n, base;
		logic [5:0] cs;
		model(m, io, a, c, b, pin);
		@(negedge clk_sys);
		mst_req[m] = 1;
		mst_io[m] = io;
		mst_we[m] = we;
		mst_addr[m] = a[23:0];
		n = 0;
		do begin
			@(negedge clk_sys);
			n++;
		end while (mst_ack_r[m] !== 1'b1 && n < 40);
		t_ack[m] = cyc;
		mst_req[m] = 0;
		check(mst_ack_r[m], 1);
		check(mst_class_r[m], c);
		if (b >= 0) check(mst_block_r[m], b);
		check(mst_rdata_r[m], c == TC_NONE ? 0 : (a ^ (16'hA5C3 + m)) & 16'hFFFF);
		if (pin >= 0) begin
			cs = 6'h3F;
			cs[pin] = 0;
			if (pin == 0 && ext_cs_pair)
				cs[1] = 0;
			base = pin == 0 ? 24'h50000 : pin < 4 ? a & 24'hC00000 : a & 24'hE00000;
			check(ext_region_select_b_r, cs);
			check(ext_we_r, we);
			check(ext_addr_r, ((a - base) >> !ext_bus_8bit) & 24'h1FFFFF);
		end
		check(ext_active_r, pin >= 0);
		check(io_sel_r, c == TC_IO);
		if (c == TC_IO) begin
			check(io_periph_r, b);
			check(io_addr_r, a & 16'hFFFF);
			check(io_we_r, we);
		end
	endtask

	// Core and first DMA engine hit one block together; d is the expected grant spacing
	task automatic pair_test(input int a, input int d);
		fork
			access(0, 0, 0, a);
			access(1, 0, 1, a + 2);
		join
		check(t_ack[1] - t_ack[0], d);
	endtask

	initial begin
		int k;
		do_reset();
		foreach (edges[i]) access(0, 0, i % 2, edges[i]);
		for (int i = 0; i < 80; i++) begin
			k = {$random(seed)} % 8;
			ext_cs_pair = $random(seed);
			ext_bus_8bit = $random(seed);
			access({$random(seed)} % 7, 0, $random(seed), mb[k] + {$random(seed)} % ms[k]);
		end
		$display("memory map test done");
		// Every peripheral but DMA3, UART and SPI is taken as out of reset and clocked; those see only unmapped display and USB accesses
		for (int p = 1; p < 24; p++)
			for (int j = 0; j < 2; j++)
				access((p + j) % 7, 1, p[0], lo[p] + (j ? sz[p] - 1 : {$random(seed)} % sz[p]));
		$display("io map test done");
		pair_test(24'h2000, 0);
		pair_test(24'h12000, 1);
		ext_cs_pair = 1;
		pair_test(24'h60000, 1);
		$display("contention test done");
		do_reset();
		access(6, 0, 0, 24'h100);
		$display("reset test done");
		results();
	end
endmodule
`default_nettype wire
